// ---- core/prot_dout_defines.svh ----
`ifndef PROT_DOUT_DEFINES_SVH
`define PROT_DOUT_DEFINES_SVH

// ---------------------------------------------------------------------------
// register map and fields
// ---------------------------------------------------------------------------
`define CFG_ADDR        12'h000
`define STATUS_ADDR     12'h004
`define CFG_RESET       16'h1800
`define CFG_WMASK       16'hff7f
`define BIT_OT1         15
`define BIT_OT3         14
`define BIT_OT5         13
`define BIT_OC2         12
`define BIT_OC4         11
`define BIT_OC6         10
`define FREQ_HI         9
`define FREQ_LO         8
`define SEL_HI          6
`define SEL_LO          0

// ---------------------------------------------------------------------------
// carrier timing, 250 MHz clock
// ---------------------------------------------------------------------------
`define CLK_KHZ         250000
`define CARRIER_BASE_KHZ_X10 139
`define CARRIER_BASE_CYCLES ((`CLK_KHZ * 10) / `CARRIER_BASE_KHZ_X10)

`endif

// ---- core/prot_dout_pkg.sv ----
package prot_dout_pkg;
    typedef struct packed {
        logic       analog_in_1_overtemp_enable;
        logic       analog_in_3_overtemp_enable;
        logic       analog_in_5_overtemp_enable;
        logic       analog_in_2_overcurrent_enable;
        logic       analog_in_4_overcurrent_enable;
        logic       analog_in_6_overcurrent_enable;
        logic [1:0] output_carrier_freq_sel;
        logic       reserved_bit;
        logic       out_sel_die_temp;
        logic       out_sel_analog_6;
        logic       out_sel_analog_4;
        logic       out_sel_analog_2;
        logic       out_sel_analog_5;
        logic       out_sel_analog_3;
        logic       out_sel_analog_1;
    } cfg_t;

    typedef struct packed {
        logic [3:0] ot_enable;
        logic [2:0] oc_enable;
    } prot_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic [31:0] prdata;
        logic        slverr;
    } regs_t;

    typedef struct packed {
        logic [14:0] cnt;
        logic [9:0]  duty;
        logic        carrier;
    } pwm_state_t;
endpackage

// ---- core/dout_modulator.sv ----
`timescale 1ns/1ns
`include "prot_dout_defines.svh"
module dout_modulator
    import prot_dout_pkg::*;
#(
    parameter int BASE_CYCLES = `CARRIER_BASE_CYCLES
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] freq_sel,
    input  wire logic       active,
    input  wire logic [9:0] duty,
    output logic            dout
);
    // -----------------------------------------------------------------------
    // carrier counter, period halves per freq code
    // -----------------------------------------------------------------------
    pwm_state_t s_q, s_d;
    logic [14:0] period;
    logic [24:0] thresh;

    // duty taken at period start, so no extra edge mid-period
    always_comb begin
        period = 15'(BASE_CYCLES >> freq_sel);
        thresh = 25'(period) * 25'(s_q.duty);
        s_d = s_q;
        if (s_q.cnt + 15'h1 >= period) begin
            s_d.cnt  = 15'h0;
            s_d.duty = duty;
        end else begin
            s_d.cnt = s_q.cnt + 15'h1;
        end
        s_d.carrier = active && ({s_q.cnt, 10'h0} < thresh);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.carrier;
endmodule // dout_modulator

// ---- core/protection_and_digital_out_config.sv ----
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "prot_dout_defines.svh"
module protection_and_digital_out_config
    import prot_dout_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  meas_die_temp,
    input  wire logic [9:0]  meas_analog_1,
    input  wire logic [9:0]  meas_analog_2,
    input  wire logic [9:0]  meas_analog_3,
    input  wire logic [9:0]  meas_analog_4,
    input  wire logic [9:0]  meas_analog_5,
    input  wire logic [9:0]  meas_analog_6,
    output prot_t            prot_enable,
    output logic             dout
);
    // -----------------------------------------------------------------------
    // apb register file
    // -----------------------------------------------------------------------
    regs_t r_q, r_d;
    cfg_t  cfg;
    logic  acc;
    logic  hit_cfg;
    logic  hit_sts;
    logic [6:0] sel;
    logic  multi_sel;

    assign cfg       = cfg_t'(r_q.cfg);
    assign sel       = r_q.cfg[`SEL_HI:`SEL_LO];
    assign multi_sel = (sel & (sel - 7'h1)) != 7'h0;
    assign acc       = psel && penable;
    assign hit_cfg   = paddr == `CFG_ADDR;
    assign hit_sts   = paddr == `STATUS_ADDR;

    always_comb begin
        r_d = r_q;
        if (psel && !penable) begin
            r_d.slverr = !(hit_cfg || (hit_sts && !pwrite));
            r_d.prdata = 32'h0;
            if (!pwrite && hit_cfg) begin
                r_d.prdata = {16'h0, r_q.cfg};
            end
            if (!pwrite && hit_sts) begin
                r_d.prdata = {30'h0, multi_sel, sel != 7'h0};
            end
        end
        if (acc && pwrite && hit_cfg) begin
            if (pstrb[0]) begin
                r_d.cfg[7:0] = pwdata[7:0] & 8'(`CFG_WMASK);
            end
            if (pstrb[1]) begin
                r_d.cfg[15:8] = pwdata[15:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q.cfg    <= `CFG_RESET;
            r_q.prdata <= 32'h0;
            r_q.slverr <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = r_q.prdata;
    assign pslverr = acc && r_q.slverr;

    // -----------------------------------------------------------------------
    // protection enables
    // -----------------------------------------------------------------------
    assign prot_enable.ot_enable = {1'b0, cfg.analog_in_1_overtemp_enable,
                                    cfg.analog_in_3_overtemp_enable,
                                    cfg.analog_in_5_overtemp_enable};
    assign prot_enable.oc_enable = {cfg.analog_in_2_overcurrent_enable,
                                    cfg.analog_in_4_overcurrent_enable,
                                    cfg.analog_in_6_overcurrent_enable};

    // -----------------------------------------------------------------------
    // channel mux and modulator
    // -----------------------------------------------------------------------
    logic [9:0] duty;
    always_comb begin
        duty = 10'h0;
        if (cfg.out_sel_analog_1) duty = meas_analog_1;
        else if (cfg.out_sel_analog_3) duty = meas_analog_3;
        else if (cfg.out_sel_analog_5) duty = meas_analog_5;
        else if (cfg.out_sel_analog_2) duty = meas_analog_2;
        else if (cfg.out_sel_analog_4) duty = meas_analog_4;
        else if (cfg.out_sel_analog_6) duty = meas_analog_6;
        else if (cfg.out_sel_die_temp) duty = meas_die_temp;
    end

    dout_modulator u_mod (
        .pclk     (pclk),
        .presetn  (presetn),
        .freq_sel (cfg.output_carrier_freq_sel),
        .active   (sel != 7'h0),
        .duty     (duty),
        .dout     (dout)
    );

    // -----------------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------------
    a_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
        (sel == 7'h0) |=> ##1 !dout) else $error("dout active with no select");
    a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
        r_q.cfg[7] == 1'b0) else $error("reserved bit set");
    a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && pwrite && hit_cfg && pstrb[1]) |=> r_q.cfg[15:8] == $past(pwdata[15:8]))
        else $error("upper cfg write lost");
    a_oc_map: assert property (@(posedge pclk) disable iff (!presetn)
        prot_enable.oc_enable[2] == r_q.cfg[`BIT_OC2])
        else $error("oc2 enable misrouted");
    a_oc6_map: assert property (@(posedge pclk) disable iff (!presetn)
        prot_enable.oc_enable[0] == r_q.cfg[`BIT_OC6])
        else $error("oc6 enable misrouted");
    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && pwrite && hit_cfg && pstrb[0]) |=> sel == $past(pwdata[6:0]))
        else $error("select write lost");
    a_ot_map: assert property (@(posedge pclk) disable iff (!presetn)
        prot_enable.ot_enable[2] == r_q.cfg[`BIT_OT1])
        else $error("ot1 enable misrouted");
endmodule // protection_and_digital_out_config

// ---- verification/dout_monitor.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// pin watcher: rise to rise period, high time
// ----------------------------------------
module dout_monitor (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        dout,
    output logic      [15:0] period,
    output logic      [15:0] high,
    output logic      [7:0]  rises
);
    logic [15:0] cnt_q;
    logic [15:0] hc_q;
    logic        prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cnt_q, hc_q, prev_q, period, high, rises} <= '0;
        end else begin
            prev_q <= dout;
            if (dout && !prev_q) begin
                period <= cnt_q;
                high   <= hc_q;
                rises  <= rises + 8'h01;
                cnt_q  <= 16'h0001;
                hc_q   <= 16'h0001;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
                hc_q  <= hc_q + {15'h0000, dout};
            end
        end
    end
endmodule // dout_monitor

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
module testbench
    import prot_dout_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, dout, hi;
    prot_t       prot_enable;
    logic [15:0] period, high;
    logic [7:0]  rises, r0;
    int          errors = 0, comparisons = 0;
    logic [9:0]  vals [7] = '{10'h100, 10'h200, 10'h300, 10'h180, 10'h280, 10'h380, 10'h064};

    always #2 pclk = ~pclk;

    protection_and_digital_out_config i_protection_and_digital_out_config (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_die_temp(vals[6]), .meas_analog_1(vals[0]),
        .meas_analog_2(vals[3]), .meas_analog_3(vals[1]), .meas_analog_4(vals[4]),
        .meas_analog_5(vals[2]), .meas_analog_6(vals[5]), .prot_enable(prot_enable),
        .dout(dout));
    dout_monitor i_dout_monitor (.pclk(pclk), .presetn(presetn), .dout(dout),
        .period(period), .high(high), .rises(rises));

    task automatic test_done();
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timed_out();
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        test_done();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) timed_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic check_duty(input int code, input int v);
        int n, p, e;
        p = 17985 >> code;
        e = p * v / 1024;
        r0 = rises;
        for (n = 0; n < 40000 && rises != r0 + 8'h02; n++) @(posedge pclk);
        if (n == 40000) timed_out();
        cmp(period, p);
        cmp(32'(high + p / 64 + 2 >= e && high <= e + p / 64 + 2), 1);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        cmp(rd, 32'h1800);
        cmp({25'h0, prot_enable}, 32'h06);
        for (int b = 10; b < 16; b++) begin
            apb(1'b1, 12'h000, 32'h1 << b);
            cmp({25'h0, prot_enable}, 32'h1 << (b - 10));
        end
        apb(1'b1, 12'h000, 32'hff81);
        apb(1'b0, 12'h000, 32'h0);
        cmp(rd, 32'hff01);
        apb(1'b0, 12'h008, 32'h0);
        cmp(err, 1'b1);
        apb(1'b1, 12'h004, 32'h0);
        cmp(err, 1'b1);
        apb(1'b1, 12'h000, 32'h0300);
        cmp(err, 1'b0);
        repeat (2) @(posedge pclk);
        r0 = rises;
        hi = 1'b0;
        repeat (500) begin
            @(posedge pclk);
            hi = hi | dout;
        end
        cmp({hi, rises}, {1'b0, r0});
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h000, (c << 8) | 32'h01);
            check_duty(c, vals[0]);
        end
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 12'h000, 32'h0300 | (32'h1 << i));
            apb(1'b0, 12'h004, 32'h0);
            cmp(rd[1:0], 2'b01);
            check_duty(3, vals[i]);
        end
        test_done();
    end
endmodule // testbench
